// ### rtl/dcpml_pkg.sv
// Purpose: Shared constants for the dual channel PID motor loop
// Assumes: 20 MHz pclk, APB register access
// Notes:   Offsets are byte addresses on 32-bit words
package dcpml_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20000000;  // Bus clock rate
  localparam int unsigned PERIOD_MS    = 16;        // Control period
  localparam int unsigned PERIOD_CYC   = CLK_HZ / 1000 * PERIOD_MS;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Mode, source, local select
  localparam logic [7:0] OFS_GAIN   = 8'h04;  // Kp, Ki, Kd
  localparam logic [7:0] OFS_CMD    = 8'h08;  // Commands A and B
  localparam logic [7:0] OFS_POWER  = 8'h0C;  // Applied power A and B
  localparam logic [7:0] OFS_STATUS = 8'h10;  // Errors A and B
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;   // Mode, 2 bits
  localparam int unsigned CTRL_ENC_BIT  = 4;   // Encoder speed feedback
  localparam int unsigned GAIN_KP_LSB   = 0;   // 8-bit gains
  localparam int unsigned GAIN_KI_LSB   = 8;
  localparam int unsigned GAIN_KD_LSB   = 16;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] KP_RST   = 8'h01;
  localparam logic [7:0] KI_RST   = 8'h00;
  localparam logic [7:0] KD_RST   = 8'h00;
  localparam logic signed [7:0] PWR_MAX = 8'sh7F;  // Saturation bound
  // Motor control selection
  typedef enum logic [1:0] {
    DCPML_MODE_POS      = 2'h0,  // Both channels in position
    DCPML_MODE_SPD_SEP  = 2'h1,  // Both closed loop speed, separate
    DCPML_MODE_SPD_MIX  = 2'h2,  // Both closed loop speed, mixed
    DCPML_MODE_SPD_APOS = 2'h3   // A in speed, B in position
  } dcpml_mode_t;
endpackage

// ### rtl/dcpml_chan_if.sv
// Purpose: Carrier between the loop top and one channel engine
// Assumes: Single pclk domain
// Notes:   Gains shared by both channels
`timescale 1ns/1ps
interface dcpml_chan_if;
  logic              tick;     // One control period strobe
  logic              clear;    // Clear history and integral
  logic signed [7:0] cmd;      // Commanded value
  logic signed [7:0] meas;     // Measured value
  logic        [7:0] kp;       // Proportional gain
  logic        [7:0] ki;       // Integral gain
  logic        [7:0] kd;       // Differential gain
  logic signed [7:0] power;    // Saturated applied power
  logic signed [8:0] err;      // Latest error
  modport ctl (output tick, clear, cmd, meas, kp, ki, kd,
               input power, err);
  modport eng (input tick, clear, cmd, meas, kp, ki, kd,
               output power, err);
endinterface

// ### rtl/dcpml_pid.sv
// Purpose: One channel PID step once per control period
// Assumes: Signed 8-bit command and measurement
// Notes:   Output saturates to applied power range, integral to +/-127*64
`timescale 1ns/1ps
module dcpml_pid (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Channel carrier
  dcpml_chan_if.eng   ch
);
  localparam int W = 20;                      // Working width
  localparam logic signed [W-1:0] LIM = W'(dcpml_pkg::PWR_MAX);
  localparam logic signed [W-1:0] ILIM = W'(127 * 64);  // Integral cap

  logic signed [8:0]   err_q;      // Previous error
  logic signed [W-1:0] acc_q;      // Integral accumulator
  logic signed [7:0]   pwr_q;      // Applied power
  logic signed [8:0]   err_w;      // New error
  logic signed [9:0]   derr_w;     // Error change
  logic signed [W-1:0] acc_sum;    // Unsaturated integral
  logic signed [W-1:0] acc_w;      // Saturated integral
  logic signed [W-1:0] p_w;        // Proportional term
  logic signed [W-1:0] i_w;        // Integral term
  logic signed [27:0]  i_wide;     // Full integral product
  logic signed [W-1:0] d_w;        // Differential term
  logic signed [W-1:0] sum_w;      // PID sum

  // Error formed from command minus measurement
  assign err_w   = 9'(ch.cmd) - 9'(ch.meas);
  assign derr_w  = 10'(err_w) - 10'(err_q);
  assign acc_sum = acc_q + W'(err_w);
  assign acc_w   = (acc_sum > ILIM) ? ILIM :
                   (acc_sum < -ILIM) ? -ILIM : acc_sum;
  assign p_w     = W'(err_w) * W'($signed({1'b0, ch.kp}));
  // Capped integral times top gain needs 22 bits, so widen first
  assign i_wide  = 28'(acc_w) * 28'($signed({1'b0, ch.ki}));
  assign i_w     = W'(i_wide >>> 6);
  assign d_w     = W'(derr_w) * W'($signed({1'b0, ch.kd}));
  assign sum_w   = p_w + i_w + d_w;
  assign ch.power = pwr_q;
  assign ch.err   = err_q;

  // Per-channel state, cleared on loop type change or reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 9'sh000;
      acc_q <= '0;
      pwr_q <= 8'sh00;
    end else if (ch.clear) begin
      err_q <= 9'sh000;
      acc_q <= '0;
      pwr_q <= 8'sh00;
    end else if (ch.tick) begin
      err_q <= err_w;
      acc_q <= acc_w;
      pwr_q <= (sum_w > LIM) ? 8'sh7F :
               (sum_w < -LIM) ? 8'sh81 : sum_w[7:0];
    end
  end

  chk_pwr_range: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q >= -8'sd127) else $error("power below range");
  chk_zero_err_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    ch.tick && !ch.clear && err_w == 0 && err_q == 0 && ch.ki == 0
    |=> pwr_q == 0) else $error("nonzero power at zero error");
  chk_p_only: assert property (@(posedge pclk) disable iff (!presetn)
    ch.tick && !ch.clear && ch.ki == 0 && ch.kd == 0 &&
    p_w <= LIM && p_w >= -LIM
    |=> pwr_q == $past(p_w[7:0])) else $error("P term wrong");
  chk_clear_state: assert property (@(posedge pclk)
    disable iff (!presetn)
    ch.clear |=> acc_q == 0 && err_q == 0) else $error("no clear");
  chk_err_hist: assert property (@(posedge pclk) disable iff (!presetn)
    ch.tick && !ch.clear |=> err_q == $past(err_w))
    else $error("history not kept");
  chk_int_cap: assert property (@(posedge pclk) disable iff (!presetn)
    acc_q <= ILIM && acc_q >= -ILIM) else $error("integral overflow");
  cov_sat_pos: cover property (@(posedge pclk) pwr_q == 8'sh7F);
  cov_sat_neg: cover property (@(posedge pclk) pwr_q == 8'sh81);
endmodule

// ### rtl/dcpml_top.sv
// Purpose: Dual channel PID motor loop with APB registers
// Assumes: 20 MHz pclk, sensor inputs synchronous to pclk
// Notes:   How it works
`timescale 1ns/1ps
module dcpml_top (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Local front panel selection
  input  wire logic              panel_mode_vld,
  input  wire logic [1:0]        panel_mode,
  // Sensors, unsigned 0..255 analog, signed encoder speed
  input  wire logic [7:0]        pos_a_adc,
  input  wire logic [7:0]        pos_b_adc,
  input  wire logic [7:0]        tach_a_adc,
  input  wire logic [7:0]        tach_b_adc,
  input  wire logic signed [7:0] enc_a_spd,
  input  wire logic signed [7:0] enc_b_spd,
  // Drive stage
  output logic signed [7:0]      power_a,
  output logic signed [7:0]      power_b
);
  parameter int unsigned PERIOD_CYC = dcpml_pkg::PERIOD_CYC;  // Tick cycles

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  dcpml_pkg::dcpml_mode_t mode_q;     // Active motor control mode
  dcpml_pkg::dcpml_mode_t mode_d;     // Next mode
  logic                   enc_q;      // Encoder speed source
  logic [7:0]             kp_q;       // Shared proportional gain
  logic [7:0]             ki_q;       // Shared integral gain
  logic [7:0]             kd_q;       // Shared differential gain
  logic signed [7:0]      cmd_a_q;    // Command A
  logic signed [7:0]      cmd_b_q;    // Command B
  logic [31:0]            rdata_d;    // Read mux
  logic                   rd_ok;      // Mapped address
  logic [22:0]            div_q;      // Period divider
  logic                   tick_q;     // Period strobe
  logic                   panel_rej_q;// Last panel request refused
  logic                   clr_a;      // Clear channel A
  logic                   clr_b;      // Clear channel B
  logic                   spd_a;      // Channel A in speed
  logic                   spd_b;      // Channel B in speed
  logic signed [7:0]      pos_a_s;    // Signed positions
  logic signed [7:0]      pos_b_s;
  logic signed [7:0]      tach_a_s;   // Signed tachometers
  logic signed [7:0]      tach_b_s;
  logic signed [7:0]      spd_a_s;    // Chosen speed feedback
  logic signed [7:0]      spd_b_s;

  dcpml_chan_if ch_a ();
  dcpml_chan_if ch_b ();

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Register map, one 32-bit word each:
  //   CTRL   [1:0] mode, [4] encoder source, [5] panel refused (RO)
  //   GAIN   [7:0] Kp, [15:8] Ki, [23:16] Kd, unsigned
  //   CMD    [7:0] command A, [15:8] command B, signed
  //   POWER  [7:0] power A, [15:8] power B, read only
  //   STATUS [8:0] error A, [24:16] error B, read only
  // Zero wait states: pready answers in the first access cycle
  // Writes land only at the edge where pready is sampled high
  // Unmapped offsets answer with pslverr and read as zero
  wire wr_en    = psel && penable && pwrite;
  wire rd_en    = psel && penable && !pwrite;
  wire hit_ctrl = paddr == dcpml_pkg::OFS_CTRL;
  wire hit_gain = paddr == dcpml_pkg::OFS_GAIN;
  wire hit_cmd  = paddr == dcpml_pkg::OFS_CMD;
  wire hit_pwr  = paddr == dcpml_pkg::OFS_POWER;
  wire hit_stat = paddr == dcpml_pkg::OFS_STATUS;
  // Mode write qualified by pready, the edge the master samples
  wire host_mode_wr = wr_en && hit_ctrl && pready;
  // Panel may only select position mode
  wire panel_ok = panel_mode_vld &&
                  panel_mode == 2'(dcpml_pkg::DCPML_MODE_POS);
  wire [1:0] host_mode = pwdata[dcpml_pkg::CTRL_MODE_LSB +: 2];

  assign rd_ok = hit_ctrl || hit_gain || hit_cmd || hit_pwr || hit_stat;

  // Mode source: host wins over panel in the same cycle
  always_comb begin
    mode_d = mode_q;
    if (host_mode_wr) begin
      mode_d = dcpml_pkg::dcpml_mode_t'(host_mode);
    end else if (panel_ok) begin
      mode_d = dcpml_pkg::DCPML_MODE_POS;
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      // Mode [1:0], encoder source [4], panel refusal [5]
      rdata_d = {26'h0, panel_rej_q, enc_q, 2'h0, 2'(mode_q)};
    end else if (hit_gain) begin
      rdata_d = {8'h00, kd_q, ki_q, kp_q};
    end else if (hit_cmd) begin
      rdata_d = {16'h0000, cmd_b_q, cmd_a_q};
    end else if (hit_pwr) begin
      rdata_d = {16'h0000, power_b, power_a};
    end else if (hit_stat) begin
      rdata_d = {7'h00, ch_b.err, 7'h00, ch_a.err};
    end
  end

  // APB slave, zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= dcpml_pkg::DCPML_MODE_POS;
      enc_q   <= 1'b0;
      kp_q    <= dcpml_pkg::KP_RST;
      ki_q    <= dcpml_pkg::KI_RST;
      kd_q    <= dcpml_pkg::KD_RST;
      cmd_a_q <= 8'sh00;
      cmd_b_q <= 8'sh00;
    end else begin
      mode_q <= mode_d;
      if (host_mode_wr && pready) begin
        enc_q <= pwdata[dcpml_pkg::CTRL_ENC_BIT];
      end
      if (wr_en && hit_gain && pready) begin
        kp_q <= pwdata[dcpml_pkg::GAIN_KP_LSB +: 8];
        ki_q <= pwdata[dcpml_pkg::GAIN_KI_LSB +: 8];
        kd_q <= pwdata[dcpml_pkg::GAIN_KD_LSB +: 8];
      end
      if (wr_en && hit_cmd && pready) begin
        cmd_a_q <= pwdata[7:0];
        cmd_b_q <= pwdata[15:8];
      end
    end
  end

  // Panel refusal flag for software
  // Held until the next panel request so it can be polled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_rej_q <= 1'b0;
    end else if (panel_mode_vld) begin
      panel_rej_q <= !panel_ok;
    end
  end

  // ---------------------------------------------------------------
  // Control period divider
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 23'h000000;
      tick_q <= 1'b0;
    end else if (div_q == 23'(PERIOD_CYC - 1)) begin
      div_q  <= 23'h000000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 23'h000001;
      tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Feedback selection
  // ---------------------------------------------------------------
  // Offset binary to signed, 0 is -128 clipped to -127
  function automatic logic signed [7:0] to_signed(input logic [7:0] v);
    logic [7:0] s;
    s = v ^ 8'h80;
    to_signed = (s == 8'h80) ? 8'sh81 : $signed(s);
  endfunction

  assign pos_a_s  = to_signed(pos_a_adc);
  assign pos_b_s  = to_signed(pos_b_adc);
  assign tach_a_s = to_signed(tach_a_adc);
  assign tach_b_s = to_signed(tach_b_adc);
  // Encoder speed is signed already and skips the offset decode
  assign spd_a_s  = enc_q ? enc_a_spd : tach_a_s;
  assign spd_b_s  = enc_q ? enc_b_spd : tach_b_s;
  assign spd_a    = mode_q != dcpml_pkg::DCPML_MODE_POS;
  assign spd_b    = mode_q == dcpml_pkg::DCPML_MODE_SPD_SEP ||
                    mode_q == dcpml_pkg::DCPML_MODE_SPD_MIX;
  // Clear a channel whose loop type changes
  assign clr_a    = spd_a != (mode_d != dcpml_pkg::DCPML_MODE_POS);
  assign clr_b    = spd_b != (mode_d == dcpml_pkg::DCPML_MODE_SPD_SEP ||
                    mode_d == dcpml_pkg::DCPML_MODE_SPD_MIX);

  // ---------------------------------------------------------------
  // Channel engines
  // ---------------------------------------------------------------
  // Both engines read the one gain set, never a per channel copy
  assign ch_a.tick  = tick_q;
  assign ch_a.clear = clr_a;
  assign ch_a.cmd   = cmd_a_q;
  assign ch_a.meas  = spd_a ? spd_a_s : pos_a_s;
  assign ch_a.kp    = kp_q;
  assign ch_a.ki    = ki_q;
  assign ch_a.kd    = kd_q;
  assign ch_b.tick  = tick_q;
  assign ch_b.clear = clr_b;
  assign ch_b.cmd   = cmd_b_q;
  assign ch_b.meas  = spd_b ? spd_b_s : pos_b_s;
  assign ch_b.kp    = kp_q;
  assign ch_b.ki    = ki_q;
  assign ch_b.kd    = kd_q;

  dcpml_pid u_pid_a (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch_a.eng)
  );

  dcpml_pid u_pid_b (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch_b.eng)
  );

  assign power_a = ch_a.power;
  assign power_b = ch_b.power;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_panel_no_speed: assert property (@(posedge pclk)
    disable iff (!presetn)
    panel_mode_vld && panel_mode != 2'h0 && !host_mode_wr
    |=> mode_q == $past(mode_q)) else $error("panel set speed mode");
  chk_tick_period: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_q |=> !tick_q) else $error("tick too long");
  chk_apos_split: assert property (@(posedge pclk)
    disable iff (!presetn)
    mode_q == dcpml_pkg::DCPML_MODE_SPD_APOS |-> spd_a && !spd_b)
    else $error("A speed B position wrong");
  chk_tach_mid: assert property (@(posedge pclk)
    disable iff (!presetn)
    tach_a_adc == 8'h80 |-> tach_a_s == 0) else $error("mid not zero");
  chk_mode_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    spd_a != $past(spd_a) |-> power_a == 0) else $error("no clear");
  // Bus handshake shape: one answer per transfer
  chk_pready_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready |=> !pready) else $error("pready held two cycles");
  // Speed feedback source follows the encoder select
  chk_enc_source: assert property (@(posedge pclk)
    disable iff (!presetn)
    enc_q && spd_a |-> ch_a.meas == enc_a_spd)
    else $error("encoder speed not used");
  // Analog end points map to full forward and full reverse
  chk_adc_ends: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tach_a_adc == 8'hFF |-> tach_a_s == 8'sd127) and
    (pos_b_adc == 8'h00 |-> pos_b_s == -8'sd127))
    else $error("analog end points wrong");
  cov_host_speed: cover property (@(posedge pclk)
    host_mode_wr && host_mode == 2'h1);
  cov_panel_rej: cover property (@(posedge pclk)
    panel_mode_vld && !panel_ok);
  cov_enc_speed: cover property (@(posedge pclk) enc_q && spd_a && tick_q);
endmodule

// ### verification/dcpml_sensor_model.sv
// Purpose: Sensor side of both motor channels, as seen by the loop
// Assumes: Values set by the bench as signed -127..+127
// Notes:   Analog codes are offset binary except full reverse, which is moved to code zero
`timescale 1ns/1ps
module dcpml_sensor_model (
  // Clock
  input  wire logic              pclk,
  // Physical quantities from the bench
  input  wire logic signed [7:0] pos_a,
  input  wire logic signed [7:0] pos_b,
  input  wire logic signed [7:0] spd_a,
  input  wire logic signed [7:0] spd_b,
  input  wire logic signed [7:0] tach_a,
  input  wire logic signed [7:0] tach_b,
  // Sensor outputs
  output logic [7:0]             pos_a_adc,
  output logic [7:0]             pos_b_adc,
  output logic [7:0]             tach_a_adc,
  output logic [7:0]             tach_b_adc,
  output logic signed [7:0]      enc_a_spd,
  output logic signed [7:0]      enc_b_spd
);
  // Offset-binary code, full reverse at the bottom of the scale
  function automatic logic [7:0] to_code(input logic signed [7:0] v);
    to_code = (v == 8'sh81) ? 8'h00 : {~v[7], v[6:0]};
  endfunction

  // Converters sample once a clock, like a free-running ADC
  always_ff @(posedge pclk) begin
    pos_a_adc  <= to_code(pos_a);
    pos_b_adc  <= to_code(pos_b);
    tach_a_adc <= to_code(tach_a);
    tach_b_adc <= to_code(tach_b);
    enc_a_spd  <= spd_a;
    enc_b_spd  <= spd_b;
  end
endmodule

// ### verification/dual_channel_pid_motor_loop_test.sv
// Purpose: Self-checking bench for the dual channel PID motor loop
// Assumes: Shortened control period of 40 cycles
// Notes:   Power is checked at the ports and through the registers
`timescale 1ns/1ps
module dual_channel_pid_motor_loop_test;
  localparam int unsigned P = 40;  // Control period in cycles
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic              pclk, presetn, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, err, panel_mode_vld;
  logic [1:0]        panel_mode;
  logic [7:0]        pos_a_adc, pos_b_adc, tach_a_adc, tach_b_adc;
  logic signed [7:0] enc_a_spd, enc_b_spd, power_a, power_b;
  logic signed [7:0] pos_a, pos_b, spd_a, spd_b, tach_a, tach_b;
  logic [7:0]        v1, v2;
  int                miscompares, comparisons;

  dcpml_top #(.PERIOD_CYC(P)) dcpml_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .panel_mode_vld(panel_mode_vld),
    .panel_mode(panel_mode), .pos_a_adc(pos_a_adc), .pos_b_adc(pos_b_adc),
    .tach_a_adc(tach_a_adc), .tach_b_adc(tach_b_adc),
    .enc_a_spd(enc_a_spd), .enc_b_spd(enc_b_spd),
    .power_a(power_a), .power_b(power_b));

  dcpml_sensor_model dcpml_sensor_model_i (
    .pclk(pclk), .pos_a(pos_a), .pos_b(pos_b), .spd_a(spd_a),
    .spd_b(spd_b), .tach_a(tach_a), .tach_b(tach_b),
    .pos_a_adc(pos_a_adc), .pos_b_adc(pos_b_adc),
    .tach_a_adc(tach_a_adc), .tach_b_adc(tach_b_adc),
    .enc_a_spd(enc_a_spd), .enc_b_spd(enc_b_spd));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons,
             miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang cut short, counted as a mismatch
  task automatic fail_now(input string msg);
    miscompares++;
    $display("MISMATCH t=%0t %s", $time, msg);
    summarize();
  endtask

  // Register value compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Drive stage compare, both channels
  task automatic cmp_pwr(input logic [7:0] ea, input logic [7:0] eb);
    comparisons++;
    if ({power_b, power_a} !== {eb, ea}) begin
      miscompares++;
      $display("MISMATCH t=%0t power got %h %h exp %h %h", $time,
               power_a, power_b, ea, eb);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_now("no pready");
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    cmp(rd & mask, exp, "register read");
  endtask

  // Whole control periods, fixed by the loop rate
  task automatic ticks(input int n);
    repeat (n * P) @(posedge pclk);
  endtask

  // Wait for channel A power to move, bounded by two periods plus 8 cycles
  task automatic wait_chg(output logic [7:0] v);
    logic [7:0] old;
    int         n;
    old = power_a;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (power_a === old && n < 2 * P + 8);
    if (power_a === old) fail_now("power did not move");
    v = power_a;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; panel_mode_vld = 1'b0;
    panel_mode = 2'h0; pos_a = 8'h00; pos_b = 8'h00; spd_a = 8'h00;
    spd_b = 8'h00; tach_a = 8'h00; tach_b = 8'h00;
    miscompares = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rd_chk(dcpml_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rd_chk(dcpml_pkg::OFS_GAIN, 32'h1, 32'hFFFFFFFF);
    rd_chk(dcpml_pkg::OFS_POWER, 32'h0, 32'hFFFFFFFF);
    wr(8'h14, 32'hFFFFFFFF);
    cmp({31'h0, err}, 32'h1, "unmapped write");
    rd_chk(8'h14, 32'h0, 32'hFFFFFFFF);
    cmp({31'h0, err}, 32'h1, "unmapped read");
    $display("test registers done");
    // Proportional term, shared gain, saturation
    wr(dcpml_pkg::OFS_GAIN, 32'h3);
    wr(dcpml_pkg::OFS_CMD, 32'h0000FB0A);
    ticks(2);
    cmp_pwr(8'h1E, 8'hF1);
    rd_chk(dcpml_pkg::OFS_POWER, 32'h0000F11E, 32'hFFFF);
    rd_chk(dcpml_pkg::OFS_STATUS, 32'h01FB000A, 32'h01FF01FF);
    pos_a <= 8'h7F;
    pos_b <= 8'h81;
    wr(dcpml_pkg::OFS_CMD, 32'h0000817F);
    ticks(2);
    cmp_pwr(8'h00, 8'h00);
    wr(dcpml_pkg::OFS_CMD, 32'h00007F00);
    ticks(2);
    cmp_pwr(8'h81, 8'h7F);
    rd_chk(dcpml_pkg::OFS_STATUS, 32'h00FE0181, 32'h01FF01FF);
    $display("test proportional done");
    // Differential term: one kick, then nothing
    pos_a <= 8'h00;
    pos_b <= 8'h00;
    wr(dcpml_pkg::OFS_CMD, 32'h0);
    wr(dcpml_pkg::OFS_GAIN, 32'h00020000);
    ticks(3);
    cmp_pwr(8'h00, 8'h00);
    wr(dcpml_pkg::OFS_CMD, 32'h00000014);
    wait_chg(v1);
    cmp({24'h0, v1}, 32'h28, "differential kick");
    wait_chg(v2);
    cmp({24'h0, v2}, 32'h00, "differential settle");
    $display("test differential done");
    // Mode change clears state; integral on encoder speed
    wr(dcpml_pkg::OFS_GAIN, 32'h1);
    ticks(2);
    cmp_pwr(8'h14, 8'h00);
    tach_a <= 8'h7F;
    wr(dcpml_pkg::OFS_CMD, 32'h00000005);
    wr(dcpml_pkg::OFS_GAIN, 32'h00004000);
    wr(dcpml_pkg::OFS_CTRL, 32'h00000011);
    rd_chk(dcpml_pkg::OFS_CTRL, 32'h11, 32'h33);
    repeat (2) @(posedge pclk);
    cmp_pwr(8'h00, 8'h00);
    wait_chg(v1);
    wait_chg(v2);
    cmp({24'h0, 8'(v2 - v1)}, 32'h05, "integral step");
    $display("test integral done");
    // Every selection, then A speed on tach with B in position
    for (int m = 0; m < 4; m++) begin
      wr(dcpml_pkg::OFS_CTRL, 32'(m));
      rd_chk(dcpml_pkg::OFS_CTRL, 32'(m), 32'h3);
    end
    wr(dcpml_pkg::OFS_GAIN, 32'h1);
    pos_b <= 8'h81;
    spd_a <= 8'h64;
    wr(dcpml_pkg::OFS_CMD, 32'h00009C64);
    ticks(3);
    cmp_pwr(8'hE5, 8'h1B);
    $display("test modes done");
    // Panel may pick position only
    for (int m = 3; m >= 0; m--) begin
      @(posedge pclk);
      panel_mode_vld <= 1'b1;
      panel_mode     <= 2'(m);
      @(posedge pclk);
      panel_mode_vld <= 1'b0;
      if (m > 0) begin
        rd_chk(dcpml_pkg::OFS_CTRL, 32'h23, 32'h23);
      end else begin
        rd_chk(dcpml_pkg::OFS_CTRL, 32'h0, 32'h23);
      end
    end
    $display("test panel done");
    summarize();
  end
endmodule
